// ### hdl/tcs_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

// =============================================================
// Register byte offsets
`define TCS_OFS_CTRL    12'h000
`define TCS_OFS_STATUS  12'h004
`define TCS_OFS_IRQ_ST  12'h008
`define TCS_OFS_IRQ_MSK 12'h00c
`define TCS_OFS_SW_TGT  12'h010
`define TCS_OFS_CMD     12'h014
`define TCS_OFS_SCALE   12'h018

// =============================================================
// Control register fields
`define TCS_CTRL_RUN_HI   0
`define TCS_CTRL_CLR_HI   1
`define TCS_CTRL_RDY_LO   2
`define TCS_CTRL_RDY_OC   3
`define TCS_CTRL_BAND_LO  4
`define TCS_CTRL_BAND_OC  5
`define TCS_CTRL_SW_EN    6
`define TCS_CTRL_SW_TGT   7
`define TCS_CTRL_SW_RUN   8
`define TCS_CTRL_RESET    9'h000

// Command register: write one to request an error clear
`define TCS_CMD_CLR 0

// Status and interrupt bit positions
`define TCS_ST_RUN      0
`define TCS_ST_ERROR    1
`define TCS_ST_READY    2
`define TCS_ST_INBAND   3
`define TCS_ST_OPEN     4
`define TCS_ST_SHORT    5
`define TCS_IRQ_BITS    4
`define TCS_IRQ_FAULT   0
`define TCS_IRQ_CLEARED 1
`define TCS_IRQ_BAND_IN 2
`define TCS_IRQ_RUN_OFF 3

// =============================================================
// Temperature scaling: codes in 1/16 degree Celsius
`define TCS_BAND_CODE   16'h0010
`define TCS_FULL_CODE   16'h0320
`define TCS_SW_TGT_RST  16'h0190

// Time after power-on before the block reports readiness
`define TCS_BOOT_NS     1000
`define TCS_CLK_NS      20
`define TCS_BOOT_CYC    ((`TCS_BOOT_NS + `TCS_CLK_NS - 1) / `TCS_CLK_NS)

`endif

// ### hdl/tcs_pkg.sv
// Types shared by the enable and status logic
package tcs_pkg;
	// Operating states of the control core
	typedef enum logic [1:0] {
		TCS_BOOT,
		TCS_IDLE,
		TCS_RUN,
		TCS_FAULT
	} tcs_state_type;
endpackage : tcs_pkg

// ### hdl/tcs_pol_in.sv
// Polarity adapter for one digital control input
`timescale 1ns/1ps
module tcs_pol_in (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin level and polarity
	input wire logic pin_level,
	input wire logic active_high,
	// Active and rising-edge results
	output logic active,
	output logic active_rise
);
	logic active_prev;

	// Register the qualified level so that the edge is clean
	always_ff @(posedge clk) begin
		if (rst) begin
			active <= 1'b0;
			active_prev <= 1'b0;
		end else begin
			active <= active_high ? pin_level : ~pin_level;
			active_prev <= active;
		end
	end

	assign active_rise = active & ~active_prev;
endmodule : tcs_pol_in

// ### hdl/tcs_pol_out.sv
// Polarity and drive-type stage for one indicator output
`timescale 1ns/1ps
module tcs_pol_out (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Logical state and configuration
	input wire logic asserted,
	input wire logic active_low,
	input wire logic open_coll,
	// Pin signals
	output logic pin_out,
	output logic pin_oe_n
);
	logic level;

	assign level = active_low ? ~asserted : asserted;

	// Open collector only pulls low; otherwise the pin is released
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_out <= 1'b0;
			pin_oe_n <= 1'b0;
		end else begin
			pin_out <= open_coll ? 1'b0 : level;
			pin_oe_n <= open_coll ? level : 1'b0;
		end
	end
endmodule : tcs_pol_out

// ### hdl/tcs_core.sv
// Enable, error and status logic of the temperature controller
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tcs_core #(
	parameter int ADC_W = 12,
	parameter int TEMP_W = 16,
	parameter int BOOT_CYC = `TCS_BOOT_CYC
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// AXI4-Lite write address and data
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Digital control inputs
	input wire logic HARDWARE_RUN_INPUT,
	input wire logic ERROR_CLEAR_INPUT,
	// Sensor front end
	input wire logic SENSOR_OPEN,
	input wire logic SENSOR_SHORT,
	input wire logic [TEMP_W-1:0] SENSOR_TEMP,
	input wire logic [ADC_W-1:0] ANALOG_TARGET_INPUT,
	// Power stage and regulation
	output logic STAGE_ENABLE,
	output logic [TEMP_W-1:0] TARGET_TEMP,
	output logic [ADC_W-1:0] MONITOR_CODE,
	// Indicator pins
	output logic READY_OUT,
	output logic READY_OE_N,
	output logic INBAND_OUT,
	output logic INBAND_OE_N,
	// Interrupt
	output logic IRQ
);
	localparam int IRQ_N = `TCS_IRQ_BITS;
	localparam logic [TEMP_W-1:0] BAND = TEMP_W'(`TCS_BAND_CODE);
	localparam logic [TEMP_W-1:0] FULL = TEMP_W'(`TCS_FULL_CODE);
	localparam logic [ADC_W-1:0] ADC_MAX = {ADC_W{1'b1}};

	tcs_pkg::tcs_state_type state_reg;
	logic [8:0] ctrl_reg;
	logic [TEMP_W-1:0] sw_tgt_reg;
	logic [TEMP_W-1:0] full_reg;
	logic [IRQ_N-1:0] irq_st_reg;
	logic [IRQ_N-1:0] irq_msk_reg;
	logic [15:0] boot_cnt_reg;
	logic err_reg;
	logic open_seen_reg;
	logic short_seen_reg;
	logic inband_reg;
	logic sw_clr_reg;
	logic run_act;
	logic clr_act;
	logic fault_now;
	logic clear_req;
	logic enable_next;
	logic inband_next;
	logic [TEMP_W-1:0] tgt_next;
	logic [TEMP_W-1:0] diff;
	logic [TEMP_W+ADC_W-1:0] tgt_prod;
	logic [TEMP_W+ADC_W-1:0] mon_prod;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_fire;
	logic [IRQ_N-1:0] irq_evt;
	logic [31:0] rd_data;

	// =============================================================
	// Input polarity stages
	// run input polarity
	tcs_pol_in u_run (
		.clk(SYS_CLK),
		.rst(RST),
		.pin_level(HARDWARE_RUN_INPUT),
		.active_high(ctrl_reg[`TCS_CTRL_RUN_HI]),
		.active(run_act),
		.active_rise()
	);
	tcs_pol_in u_clr (
		.clk(SYS_CLK),
		.rst(RST),
		.pin_level(ERROR_CLEAR_INPUT),
		.active_high(ctrl_reg[`TCS_CTRL_CLR_HI]),
		.active(clr_act),
		.active_rise()
	);

	// =============================================================
	// Fault latch
	assign fault_now = SENSOR_OPEN | SENSOR_SHORT;
	// pin or software request, never resets the core
	// software clear joins the pin clear
	assign clear_req = clr_act | sw_clr_reg;

	// sensor fault latches; a live fault wins over a clear
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			err_reg <= 1'b0;
			open_seen_reg <= 1'b0;
			short_seen_reg <= 1'b0;
		end else if (fault_now) begin
			err_reg <= 1'b1;
			open_seen_reg <= open_seen_reg | SENSOR_OPEN;
			short_seen_reg <= short_seen_reg | SENSOR_SHORT;
		end else if (clear_req) begin
			err_reg <= 1'b0;
			open_seen_reg <= 1'b0;
			short_seen_reg <= 1'b0;
		end
	end

	// =============================================================
	// Operating state and enable
	// AND of run input, software run bit when software enable is set, and no error
	// software enable never bypasses the run input
	assign enable_next = run_act & ~err_reg & ~fault_now
		& (~ctrl_reg[`TCS_CTRL_SW_EN] | ctrl_reg[`TCS_CTRL_SW_RUN]);

	// Boot counter delays readiness after power-on
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_reg <= tcs_pkg::TCS_BOOT;
			boot_cnt_reg <= 16'h0000;
		end else begin
			unique case (state_reg)
				tcs_pkg::TCS_BOOT: begin
					boot_cnt_reg <= boot_cnt_reg + 16'h0001;
					if (boot_cnt_reg == 16'(BOOT_CYC - 1))
						state_reg <= tcs_pkg::TCS_IDLE;
				end
				tcs_pkg::TCS_IDLE, tcs_pkg::TCS_RUN, tcs_pkg::TCS_FAULT: begin
					if (err_reg | fault_now)
						state_reg <= tcs_pkg::TCS_FAULT;
					else if (enable_next)
						state_reg <= tcs_pkg::TCS_RUN;
					else
						state_reg <= tcs_pkg::TCS_IDLE;
				end
			endcase
		end
	end

	// Power stage follows the run state, a fault drops it at once
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			STAGE_ENABLE <= 1'b0;
		else
			STAGE_ENABLE <= (state_reg != tcs_pkg::TCS_BOOT) & enable_next;
	end

	// =============================================================
	// Target selection and scaling
	// linear code to 0..50 C, full scale held in a register
	assign tgt_prod = ANALOG_TARGET_INPUT * full_reg;
	// choose the software value or the analog input
	assign tgt_next = ctrl_reg[`TCS_CTRL_SW_TGT] ? sw_tgt_reg
		: TEMP_W'(tgt_prod / (TEMP_W+ADC_W)'(ADC_MAX));
	// monitor code proportional to measured temperature
	assign mon_prod = SENSOR_TEMP * ADC_MAX;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			TARGET_TEMP <= '0;
			MONITOR_CODE <= '0;
		end else begin
			TARGET_TEMP <= tgt_next;
			if (SENSOR_TEMP >= full_reg)
				MONITOR_CODE <= ADC_MAX;
			else
				MONITOR_CODE <= ADC_W'(mon_prod / (TEMP_W+ADC_W)'(full_reg));
		end
	end

	// =============================================================
	// Band detector
	assign diff = (SENSOR_TEMP > TARGET_TEMP) ? SENSOR_TEMP - TARGET_TEMP
		: TARGET_TEMP - SENSOR_TEMP;
	assign inband_next = STAGE_ENABLE & (diff <= BAND);

	always_ff @(posedge SYS_CLK) begin
		if (RST)
			inband_reg <= 1'b0;
		else
			inband_reg <= inband_next;
	end

	// =============================================================
	// Indicator stages
	// ready after boot, dropped on any error
	tcs_pol_out u_ready (
		.clk(SYS_CLK),
		.rst(RST),
		.asserted((state_reg != tcs_pkg::TCS_BOOT) & ~err_reg & ~fault_now),
		.active_low(ctrl_reg[`TCS_CTRL_RDY_LO]),
		.open_coll(ctrl_reg[`TCS_CTRL_RDY_OC]),
		.pin_out(READY_OUT),
		.pin_oe_n(READY_OE_N)
	);
	tcs_pol_out u_band (
		.clk(SYS_CLK),
		.rst(RST),
		.asserted(inband_reg),
		.active_low(ctrl_reg[`TCS_CTRL_BAND_LO]),
		.open_coll(ctrl_reg[`TCS_CTRL_BAND_OC]),
		.pin_out(INBAND_OUT),
		.pin_oe_n(INBAND_OE_N)
	);

	// =============================================================
	// AXI4-Lite write path: address and data taken in either order
	// one register protocol whatever the host link
	assign wr_fire = aw_hold_reg & w_hold_reg & ~S_AXI_BVALID;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			// Always OKAY: unmapped writes are silently ignored
			S_AXI_BRESP <= 2'b00;
		end else begin
			S_AXI_AWREADY <= ~aw_hold_reg & ~S_AXI_AWREADY;
			S_AXI_WREADY <= ~w_hold_reg & ~S_AXI_WREADY;
			if (S_AXI_AWVALID & S_AXI_AWREADY) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID & S_AXI_WREADY) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_fire) begin
				S_AXI_BVALID <= 1'b1;
			end else if (S_AXI_BVALID & S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
			end
		end
	end

	// Register writes; byte lane 0 carries control bits 7:0, lane 1 bit 8, lanes 0-1 target
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ctrl_reg <= `TCS_CTRL_RESET;
			sw_tgt_reg <= TEMP_W'(`TCS_SW_TGT_RST);
			full_reg <= FULL;
			irq_msk_reg <= '0;
			sw_clr_reg <= 1'b0;
		end else begin
			sw_clr_reg <= 1'b0;
			if (wr_fire) begin
				unique case (aw_addr_reg & 12'hffc)
					`TCS_OFS_CTRL: begin
						if (w_strb_reg[0])
							ctrl_reg[7:0] <= w_data_reg[7:0];
						if (w_strb_reg[1])
							ctrl_reg[8] <= w_data_reg[8];
					end
					`TCS_OFS_IRQ_MSK:
						if (w_strb_reg[0])
							irq_msk_reg <= w_data_reg[IRQ_N-1:0];
					`TCS_OFS_SW_TGT:
						if (&w_strb_reg[1:0])
							sw_tgt_reg <= w_data_reg[TEMP_W-1:0];
					`TCS_OFS_SCALE:
						if (&w_strb_reg[1:0])
							full_reg <= w_data_reg[TEMP_W-1:0];
					`TCS_OFS_CMD:
						sw_clr_reg <= w_strb_reg[0] & w_data_reg[`TCS_CMD_CLR];
					default: begin
					end
				endcase
			end
		end
	end

	// =============================================================
	// Interrupt status: set wins over a write-one clear
	assign irq_evt = {run_act & ~enable_next & STAGE_ENABLE,
		inband_next & ~inband_reg, err_reg & clear_req & ~fault_now,
		fault_now & ~err_reg};

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			irq_st_reg <= '0;
			IRQ <= 1'b0;
		end else begin
			if (wr_fire && (aw_addr_reg & 12'hffc) == `TCS_OFS_IRQ_ST
				&& w_strb_reg[0])
				irq_st_reg <= (irq_st_reg & ~w_data_reg[IRQ_N-1:0]) | irq_evt;
			else
				irq_st_reg <= irq_st_reg | irq_evt;
			IRQ <= |(irq_st_reg & irq_msk_reg);
		end
	end

	// =============================================================
	// Read path: one cycle to ARREADY, data the cycle after
	always_comb begin
		rd_data = 32'h00000000;
		unique case (S_AXI_ARADDR & 12'hffc)
			`TCS_OFS_CTRL: rd_data[8:0] = ctrl_reg;
			`TCS_OFS_STATUS: rd_data[5:0] = {short_seen_reg, open_seen_reg,
				inband_reg, (state_reg != tcs_pkg::TCS_BOOT) & ~err_reg,
				err_reg, STAGE_ENABLE};
			`TCS_OFS_IRQ_ST: rd_data[IRQ_N-1:0] = irq_st_reg;
			`TCS_OFS_IRQ_MSK: rd_data[IRQ_N-1:0] = irq_msk_reg;
			`TCS_OFS_SW_TGT: rd_data[TEMP_W-1:0] = sw_tgt_reg;
			`TCS_OFS_SCALE: rd_data[TEMP_W-1:0] = full_reg;
			default: rd_data = 32'h00000000;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			// Always OKAY: unmapped reads return zero
			S_AXI_RRESP <= 2'b00;
		end else begin
			S_AXI_ARREADY <= ~S_AXI_RVALID & ~S_AXI_ARREADY;
			if (S_AXI_ARVALID & S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_data;
			end else if (S_AXI_RVALID & S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// =============================================================
	// Checks
	fault_stops_stage_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		fault_now |=> !STAGE_ENABLE) else $error("stage on during fault");
	fault_latches_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		fault_now |=> err_reg) else $error("fault not latched");
	clear_drops_err_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		err_reg && clear_req && !fault_now |=> !err_reg)
		else $error("error not cleared");
	run_enables_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		state_reg == tcs_pkg::TCS_IDLE && enable_next |=> STAGE_ENABLE)
		else $error("run input ignored");
	run_needed_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		!run_act |=> !STAGE_ENABLE) else $error("stage on without run");
	sw_enable_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		ctrl_reg[`TCS_CTRL_SW_EN] && !ctrl_reg[`TCS_CTRL_SW_RUN]
		|=> !STAGE_ENABLE) else $error("software enable bypassed");
	band_needs_en_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		inband_reg |-> $past(STAGE_ENABLE)) else $error("band while off");
	ready_drops_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		err_reg && !ctrl_reg[`TCS_CTRL_RDY_LO] && !ctrl_reg[`TCS_CTRL_RDY_OC]
		&& $stable(ctrl_reg) |=> !READY_OUT) else $error("ready with error");
	sw_target_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		ctrl_reg[`TCS_CTRL_SW_TGT] |=> TARGET_TEMP == $past(sw_tgt_reg))
		else $error("software target not used");
endmodule : tcs_core

// ### verification/tcs_field_model.sv
// Field-side model: run and clear switches, pulled-up indicator lines
`timescale 1ns/1ps
module tcs_field_model (
	// Operator intent and wiring polarity
	input wire logic run_on,
	input wire logic clear_on,
	input wire logic run_high,
	input wire logic clear_high,
	// Switch pins towards the block
	output logic run_pin,
	output logic clear_pin,
	// Indicator drivers from the block
	input wire logic ready_out,
	input wire logic ready_oe_n,
	input wire logic inband_out,
	input wire logic inband_oe_n,
	// Resolved indicator lines
	output logic ready_line,
	output logic inband_line
);
	// =============================================================
	// Switch wiring
	// run switch level
	// The operator closes the run switch even when software enables
	assign run_pin = run_high ? run_on : ~run_on;
	assign clear_pin = clear_high ? clear_on : ~clear_on;
	// =============================================================
	// Indicator lines
	// pulled-up lines
	// A released open-collector line floats up to the pull-up, not low
	assign ready_line = ready_oe_n ? 1'b1 : ready_out;
	assign inband_line = inband_oe_n ? 1'b1 : inband_out;
endmodule : tcs_field_model

// ### verification/tcs_core_tb.sv
// Self-checking bench for the enable and status logic
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tcs_core_tb;
	// =============================================================
	// Signals
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000, analog_tgt = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic sensor_open = 1'b0, sensor_short = 1'b0;
	logic [15:0] sensor_temp = 16'h0000;
	logic run_on = 1'b0, clear_on = 1'b0, run_high = 1'b0;
	logic clear_high = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, run_pin, clear_pin;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic stage, rdy_out, rdy_oe_n, ib_out, ib_oe_n, irq;
	logic ready_line, inband_line;
	logic [15:0] target;
	logic [11:0] monitor;
	logic [31:0] exp_q[$];
	int n_mismatch = 0;
	int check_count = 0;
	int rnd;
	logic [11:0] ofs[6] = '{`TCS_OFS_CTRL, `TCS_OFS_IRQ_MSK, `TCS_OFS_SW_TGT,
		`TCS_OFS_SCALE, `TCS_OFS_STATUS, 12'h100};
	logic [31:0] rst_val[6] = '{32'h0, 32'h0, 32'h190, 32'h320, 32'h4, 32'h0};
	logic [15:0] dlt[4] = '{16'h0010, 16'hfff0, 16'h0011, 16'hffef};
	localparam logic [31:0] RH = 32'h1 << `TCS_CTRL_RUN_HI;
	localparam logic [31:0] ST = 32'h1 << `TCS_CTRL_SW_TGT;

	// Clock at 50 MHz
	always #10 sys_clk = ~sys_clk;

	// =============================================================
	// Design and field model
	tcs_core #(.BOOT_CYC(4)) uut (.SYS_CLK(sys_clk), .RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(1'b1), .HARDWARE_RUN_INPUT(run_pin),
		.ERROR_CLEAR_INPUT(clear_pin), .SENSOR_OPEN(sensor_open),
		.SENSOR_SHORT(sensor_short), .SENSOR_TEMP(sensor_temp),
		.ANALOG_TARGET_INPUT(analog_tgt), .STAGE_ENABLE(stage),
		.TARGET_TEMP(target), .MONITOR_CODE(monitor), .READY_OUT(rdy_out),
		.READY_OE_N(rdy_oe_n), .INBAND_OUT(ib_out), .INBAND_OE_N(ib_oe_n),
		.IRQ(irq));
	tcs_field_model field (.run_on(run_on), .clear_on(clear_on),
		.run_high(run_high), .clear_high(clear_high), .run_pin(run_pin),
		.clear_pin(clear_pin), .ready_out(rdy_out), .ready_oe_n(rdy_oe_n),
		.inband_out(ib_out), .inband_oe_n(ib_oe_n), .ready_line(ready_line),
		.inband_line(inband_line));

	// =============================================================
	// Helpers
	task automatic check(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	function automatic logic near(input logic [31:0] a, b);
		return (a > b) ? (a - b <= 1) : (b - a <= 1);
	endfunction : near

	task automatic final_report();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : settle

	// Write: both channels offered together, each released when taken
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge sys_clk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge sys_clk);
		check("bresp", bresp, 32'h0);
	endtask : axi_write

	// Read: the expected word is noted before the request goes out
	task automatic axi_read(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge sys_clk);
	endtask : axi_read

	// Read data watcher takes the oldest note off the queue
	always @(posedge sys_clk) begin
		if (rvalid === 1'b1) begin
			check("rresp", rresp, 32'h0);
			if (exp_q.size() == 0) begin
				check("read_note", 32'h1, 32'h0);
			end else begin
				check("rdata", rdata, exp_q.pop_front());
			end
		end
	end

	// Watchdog sized well above the full sequence
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		final_report();
	end

	// =============================================================
	// Scenarios
	initial begin
		void'($urandom(32'hcff92c2b));
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		settle(2);
		check("ready_boot", ready_line, 1'b0);
		settle(10);
		check("ready_up", ready_line, 1'b1);
		check("ready_oe_n", rdy_oe_n, 1'b0);
		for (int i = 0; i < 6; i++) begin
			axi_read(ofs[i], rst_val[i]);
		end
		// Run polarity: low-active, then reconfigured to high-active
		run_on <= 1'b1;
		settle(4);
		check("stage_low_act", stage, 1'b1);
		axi_write(`TCS_OFS_CTRL, RH);
		settle(4);
		check("stage_wrong_pol", stage, 1'b0);
		run_high <= 1'b1;
		settle(4);
		check("stage_high_act", stage, 1'b1);
		// Software enable mode still needs the run pin
		axi_write(`TCS_OFS_CTRL, RH | (32'h1 << `TCS_CTRL_SW_EN));
		settle(4);
		check("stage_sw_off", stage, 1'b0);
		axi_write(`TCS_OFS_CTRL, RH | (32'h3 << `TCS_CTRL_SW_EN) | 32'h100);
		settle(4);
		check("stage_sw_on", stage, 1'b1);
		run_on <= 1'b0;
		settle(4);
		check("stage_sw_nopin", stage, 1'b0);
		run_on <= 1'b1;
		// Analog target mapping full-scale point and a random code
		axi_write(`TCS_OFS_CTRL, RH);
		analog_tgt <= 12'hfff;
		settle(4);
		check("target_full", target, 16'h0320);
		rnd = $urandom_range(12'hffe, 1);
		analog_tgt <= rnd[11:0];
		settle(4);
		check("target_map", near(target, rnd * 32'h320 / 32'hfff), 1);
		axi_write(`TCS_OFS_CTRL, RH | ST);
		axi_write(`TCS_OFS_SW_TGT, 32'h123);
		settle(4);
		check("target_sw", target, 16'h0123);
		axi_write(`TCS_OFS_SW_TGT, 32'h190);
		// Band edges around 25 C, then a random point inside
		for (int i = 0; i < 4; i++) begin
			sensor_temp <= 16'h0190 + dlt[i];
			settle(5);
			check("inband_edge", inband_line, (i < 2));
		end
		rnd = $urandom_range(32, 0);
		sensor_temp <= 16'h0180 + rnd[15:0];
		settle(5);
		check("inband_rnd", inband_line, 1'b1);
		run_on <= 1'b0;
		settle(5);
		check("inband_off", inband_line, 1'b0);
		run_on <= 1'b1;
		// Indicators inverted and open-collector
		axi_write(`TCS_OFS_CTRL, RH | ST | 32'h3c);
		settle(5);
		check("ready_oc_lo", {rdy_oe_n, ready_line}, 2'b00);
		check("inband_oc_lo", {ib_oe_n, inband_line}, 2'b00);
		axi_write(`TCS_OFS_CTRL, RH | ST | 32'h08);
		settle(5);
		check("ready_oc_hi", {rdy_out, ready_line}, 2'b01);
		axi_write(`TCS_OFS_CTRL, RH | ST);
		// Monitor output scaling and saturation
		sensor_temp <= 16'h0320;
		settle(4);
		check("monitor_full", monitor, 12'hfff);
		sensor_temp <= 16'hffff;
		settle(4);
		check("monitor_sat", monitor, 12'hfff);
		sensor_temp <= 16'h00a0;
		settle(4);
		check("monitor_mid", near(monitor, 32'h333), 1);
		sensor_temp <= 16'h0000;
		// Open sensor, interrupt, pin clear
		axi_write(`TCS_OFS_IRQ_MSK, 32'h1);
		axi_write(`TCS_OFS_IRQ_ST, 32'hf);
		sensor_open <= 1'b1;
		settle(5);
		check("fault_stage", {stage, ready_line, irq}, 3'b001);
		axi_read(`TCS_OFS_STATUS, 32'h12);
		sensor_open <= 1'b0;
		axi_write(`TCS_OFS_IRQ_ST, 32'h1);
		settle(4);
		check("irq_w1c", {irq, stage}, 2'b00);
		clear_on <= 1'b1;
		settle(4);
		clear_on <= 1'b0;
		settle(5);
		check("pin_clear", {stage, ready_line}, 2'b11);
		// Run dropped at the fault, then the error-cleared event
		axi_read(`TCS_OFS_IRQ_ST, 32'ha);
		// Shorted sensor, masked interrupt, software clear
		axi_write(`TCS_OFS_IRQ_MSK, 32'h0);
		sensor_short <= 1'b1;
		settle(5);
		check("short_masked", {stage, irq}, 2'b00);
		axi_write(`TCS_OFS_CMD, 32'h1);
		settle(4);
		check("live_fault", stage, 1'b0);
		axi_write(`TCS_OFS_IRQ_MSK, 32'h1);
		settle(3);
		check("irq_unmask", irq, 1'b1);
		sensor_short <= 1'b0;
		axi_write(`TCS_OFS_CMD, 32'h1);
		settle(5);
		check("cmd_clear", {stage, ready_line}, 2'b11);
		// Clear input rewired and reconfigured to high-active
		clear_high <= 1'b1;
		axi_write(`TCS_OFS_CTRL, RH | ST | 32'h2);
		sensor_open <= 1'b1;
		settle(3);
		sensor_open <= 1'b0;
		settle(4);
		check("err_held", stage, 1'b0);
		clear_on <= 1'b1;
		settle(4);
		clear_on <= 1'b0;
		settle(5);
		check("clear_high_act", stage, 1'b1);
		axi_write(12'h100, 32'hffff_ffff);
		axi_read(12'h100, 32'h0);
		settle(4);
		check("queue_empty", exp_q.size(), 0);
		final_report();
	end
endmodule : tcs_core_tb
